// ===== logic/block_ram_pkg.sv
`default_nettype none
package block_ram_pkg;

    // shared cell array
    localparam int CELL_COUNT = 4096;
    localparam int CELL_AW    = 12;
    localparam int MAX_WIDTH  = 16;

    typedef logic [CELL_AW-1:0] cell_idx_t;

    // direction allowed on a port
    typedef enum logic [1:0] {
        PM_RW = 2'b00,
        PM_RO = 2'b01,
        PM_WO = 2'b10
    } port_mode_e;

    // reset values
    localparam logic [MAX_WIDTH-1:0]  DOUT_RST_VAL = 16'h0000;
    localparam logic [CELL_COUNT-1:0] INIT_DEFAULT = '0;

    // default control pin polarity: active high, no inversion
    localparam logic POL_NORMAL = 1'b0;

endpackage : block_ram_pkg
`default_nettype wire

// ===== logic/ram_port_engine.sv
`timescale 1ns/1ps
`default_nettype none
module ram_port_engine
    import block_ram_pkg::*;
#(
    parameter int         WIDTH   = 16,
    parameter port_mode_e MODE    = PM_RW,
    parameter logic       CLK_INV = POL_NORMAL,
    parameter logic       EN_INV  = POL_NORMAL,
    parameter logic       WE_INV  = POL_NORMAL,
    parameter logic       RST_INV = POL_NORMAL,
    parameter int         AW      = CELL_AW - $clog2(WIDTH)
) (
    // system
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    // port pins
    input  wire logic                  port_clk,
    input  wire logic                  port_en,
    input  wire logic                  port_we,
    input  wire logic                  port_rst,
    input  wire logic [AW-1:0]         port_addr,
    input  wire logic [WIDTH-1:0]      write_data_in,
    // array side
    input  wire logic [CELL_COUNT-1:0] cells,
    output logic                       wr_stb,
    output cell_idx_t                  wr_base,
    output logic [WIDTH-1:0]           wr_data,
    // read side
    output logic [WIDTH-1:0]           data_out
);
    // depth and address width follow the port width
    localparam int LOG_W = $clog2(WIDTH);

    logic             clk_prev_ff;
    logic [WIDTH-1:0] data_out_ff;
    logic             port_edge;
    logic             en_act;
    logic             we_act;
    logic             rst_act;
    logic             do_read;
    logic             do_write;
    cell_idx_t        base;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_prev_ff <= CLK_INV;
        end else begin
            clk_prev_ff <= port_clk;
        end
    end

    assign port_edge = (port_clk ^ CLK_INV) & ~(clk_prev_ff ^ CLK_INV);
    assign en_act    = port_edge & (port_en ^ EN_INV);
    assign we_act    = port_we ^ WE_INV;
    assign rst_act   = port_rst ^ RST_INV;

    assign do_write  = en_act & we_act & (MODE != PM_RO);
    assign do_read   = en_act & ~we_act & (MODE != PM_WO);

    assign base      = cell_idx_t'(port_addr) << LOG_W;

    assign wr_stb    = do_write;
    assign wr_base   = base;
    assign wr_data   = write_data_in;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            data_out_ff <= DOUT_RST_VAL[WIDTH-1:0];
        end else if (en_act && rst_act) begin
            data_out_ff <= DOUT_RST_VAL[WIDTH-1:0];
        end else if (do_write) begin
            data_out_ff <= write_data_in;
        end else if (do_read) begin
            data_out_ff <= cells[base +: WIDTH];
        end
    end

    assign data_out = data_out_ff;

endmodule // ram_port_engine
`default_nettype wire

// ===== logic/dual_port_block_ram.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - one shared array of 4096 single-bit cells seen by both ports.
// - port width 1,2,4,8,16 with depth 4096 down to 256; address 12..8 bits.
// - each port is read/write, read-only or write-only with its own width.
// - ports fully independent, no arbitration between them.
// - each port synchronous to its own clock; inputs sampled on its edge.
// - read captures address on the edge and shows addressed data.
// - output never follows address combinationally.
// - write stores input data on one edge and mirrors it on output.
// - active write strobe writes input bus and reflects it on output.
// - inactive write strobe at enabled edge performs a read.
// - enable gates read, write and output reset.
// - disabled port holds its output and writes nothing.
// - output changes only on another read, write or enabled output reset.
// - clock, enable, write strobe and reset each have inversion option.
// - width W at address A covers cells A*W to (A+1)*W-1.
// - enabled reset zeroes output; an active write strobe still writes cells; other port untouched.
// - write-read conflict: write succeeds, writer output right, reader undefined.
// - array loads configured 4096 initial bits, unspecified bits zero.
module dual_port_block_ram
    import block_ram_pkg::*;
#(
    parameter int                    WIDTH_A   = 16,
    parameter int                    WIDTH_B   = 16,
    parameter port_mode_e            MODE_A    = PM_RW,
    parameter port_mode_e            MODE_B    = PM_RW,
    parameter logic                  CLK_INV_A = POL_NORMAL,
    parameter logic                  EN_INV_A  = POL_NORMAL,
    parameter logic                  WE_INV_A  = POL_NORMAL,
    parameter logic                  RST_INV_A = POL_NORMAL,
    parameter logic                  CLK_INV_B = POL_NORMAL,
    parameter logic                  EN_INV_B  = POL_NORMAL,
    parameter logic                  WE_INV_B  = POL_NORMAL,
    parameter logic                  RST_INV_B = POL_NORMAL,
    parameter logic [CELL_COUNT-1:0] INIT_BITS = INIT_DEFAULT,
    parameter int                    AW_A      = CELL_AW - $clog2(WIDTH_A),
    parameter int                    AW_B      = CELL_AW - $clog2(WIDTH_B)
) (
    // system
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    // port a
    input  wire logic               port_clk_a,
    input  wire logic               port_en_a,
    input  wire logic               port_we_a,
    input  wire logic               port_rst_a,
    input  wire logic [AW_A-1:0]    port_addr_a,
    input  wire logic [WIDTH_A-1:0] write_data_in_a,
    output logic      [WIDTH_A-1:0] data_out_a,
    // port b
    input  wire logic               port_clk_b,
    input  wire logic               port_en_b,
    input  wire logic               port_we_b,
    input  wire logic               port_rst_b,
    input  wire logic [AW_B-1:0]    port_addr_b,
    input  wire logic [WIDTH_B-1:0] write_data_in_b,
    output logic      [WIDTH_B-1:0] data_out_b
);
    logic [CELL_COUNT-1:0] cells_ff;
    logic                  wr_stb_a;
    cell_idx_t             wr_base_a;
    logic [WIDTH_A-1:0]    wr_data_a;
    logic                  wr_stb_b;
    cell_idx_t             wr_base_b;
    logic [WIDTH_B-1:0]    wr_data_b;

    localparam int LOG_A = $clog2(WIDTH_A);
    localparam int LOG_B = $clog2(WIDTH_B);

    cell_idx_t             word_a;
    cell_idx_t             word_b;
    logic [CELL_COUNT-1:0] hit_a;
    logic [CELL_COUNT-1:0] hit_b;

    ram_port_engine #(
        .WIDTH   (WIDTH_A),
        .MODE    (MODE_A),
        .CLK_INV (CLK_INV_A),
        .EN_INV  (EN_INV_A),
        .WE_INV  (WE_INV_A),
        .RST_INV (RST_INV_A),
        .AW      (AW_A)
    ) u_port_a (
        .core_clk      (core_clk),
        .rst_n         (rst_n),
        .port_clk      (port_clk_a),
        .port_en       (port_en_a),
        .port_we       (port_we_a),
        .port_rst      (port_rst_a),
        .port_addr     (port_addr_a),
        .write_data_in (write_data_in_a),
        .cells         (cells_ff),
        .wr_stb        (wr_stb_a),
        .wr_base       (wr_base_a),
        .wr_data       (wr_data_a),
        .data_out      (data_out_a)
    );

    ram_port_engine #(
        .WIDTH   (WIDTH_B),
        .MODE    (MODE_B),
        .CLK_INV (CLK_INV_B),
        .EN_INV  (EN_INV_B),
        .WE_INV  (WE_INV_B),
        .RST_INV (RST_INV_B),
        .AW      (AW_B)
    ) u_port_b (
        .core_clk      (core_clk),
        .rst_n         (rst_n),
        .port_clk      (port_clk_b),
        .port_en       (port_en_b),
        .port_we       (port_we_b),
        .port_rst      (port_rst_b),
        .port_addr     (port_addr_b),
        .write_data_in (write_data_in_b),
        .cells         (cells_ff),
        .wr_stb        (wr_stb_b),
        .wr_base       (wr_base_b),
        .wr_data       (wr_data_b),
        .data_out      (data_out_b)
    );

    // word index of each pending write
    assign word_a = wr_base_a >> LOG_A;
    assign word_b = wr_base_b >> LOG_B;

    // shared array with initial load, one cell per entry
    for (genvar i = 0; i < CELL_COUNT; i++) begin : g_cell
        // cell i is bit i%W of word i/W
        assign hit_a[i] = wr_stb_a && (cell_idx_t'(i >> LOG_A) == word_a);
        assign hit_b[i] = wr_stb_b && (cell_idx_t'(i >> LOG_B) == word_b);

        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                cells_ff[i] <= INIT_BITS[i];
            end else if (hit_b[i]) begin
                // same-cell collision left to user, port b lands
                cells_ff[i] <= wr_data_b[i % WIDTH_B];
            end else if (hit_a[i]) begin
                cells_ff[i] <= wr_data_a[i % WIDTH_A];
            end
        end
    end

endmodule // dual_port_block_ram
`default_nettype wire

// ===== tb/dual_port_block_ram_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dual_port_block_ram_assertions #(
    parameter int WIDTH_A = 16,
    parameter int WIDTH_B = 16
) (
    // system
    input wire logic               core_clk,
    input wire logic               rst_n,
    // port a
    input wire logic               port_clk_a,
    input wire logic               port_en_a,
    input wire logic               port_we_a,
    input wire logic               port_rst_a,
    input wire logic [WIDTH_A-1:0] write_data_in_a,
    input wire logic [WIDTH_A-1:0] data_out_a,
    // port b
    input wire logic               port_clk_b,
    input wire logic               port_en_b,
    input wire logic               port_we_b,
    input wire logic               port_rst_b,
    input wire logic [WIDTH_B-1:0] write_data_in_b,
    input wire logic [WIDTH_B-1:0] data_out_b
);
    logic clk_a_ff;
    logic clk_b_ff;
    logic tk_a;
    logic tk_b;
    // port clock history, inactive in reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_a_ff <= 1'b0;
            clk_b_ff <= 1'b0;
        end else begin
            clk_a_ff <= port_clk_a;
            clk_b_ff <= port_clk_b;
        end
    end
    assign tk_a = port_en_a & port_clk_a & ~clk_a_ff;
    assign tk_b = port_en_b & port_clk_b & ~clk_b_ff;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    zero_out_a_a: assert property ($rose(rst_n) |-> data_out_a == '0) else $error("a not zero");
    zero_out_b_a: assert property ($rose(rst_n) |-> data_out_b == '0) else $error("b not zero");
    hold_a_a: assert property (!tk_a |=> $stable(data_out_a)) else $error("a moved idle");
    hold_b_a: assert property (!tk_b |=> $stable(data_out_b)) else $error("b moved idle");
    mirror_a_a: assert property (tk_a && port_we_a && !port_rst_a |=> data_out_a == $past(write_data_in_a))
        else $error("a no mirror");
    mirror_b_a: assert property (tk_b && port_we_b && !port_rst_b |=> data_out_b == $past(write_data_in_b))
        else $error("b no mirror");
    clear_a_a: assert property (tk_a && port_rst_a |=> data_out_a == '0) else $error("a not cleared");
    clear_b_a: assert property (tk_b && port_rst_b |=> data_out_b == '0) else $error("b not cleared");
    cover property (tk_a && port_we_a);
    cover property (tk_b && port_we_b);
    cover property (tk_a && port_rst_a);
endmodule // dual_port_block_ram_assertions
`default_nettype wire

// ===== tb/port_user.sv
`timescale 1ns/1ps
`default_nettype none
module port_user #(
    parameter int AW = 8,
    parameter int W  = 16
) (
    // request from bench
    input  wire logic          core_clk,
    input  wire logic          go,
    input  wire logic [2:0]    ctl,
    input  wire logic [AW-1:0] addr,
    input  wire logic [W-1:0]  din,
    // port pins
    output logic               pclk,
    output logic               en,
    output logic               we,
    output logic               rst,
    output logic [AW-1:0]      pa,
    output logic [W-1:0]       pd
);
    initial {pclk, en, we, rst, pa, pd} = '0;
    always @(posedge core_clk) begin
        if (go && !pclk) begin
            {en, we, rst} <= ctl;
            pa <= addr;
            pd <= din;
            pclk <= 1'b1;
        end else begin
            // released bus keeps changing
            pclk <= 1'b0;
            pa <= ~pa;
            pd <= ~pd;
        end
    end
endmodule // port_user
`default_nettype wire

// ===== tb/dual_port_block_ram_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dual_port_block_ram_bench;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        go_a = 1'b0;
    logic        go_b = 1'b0;
    logic [2:0]  ctl = 3'h0;
    logic [9:0]  addr = 10'h000;
    logic [15:0] din = 16'h0000;
    logic        ca, ea, wa, ra, cb, eb, wb, rb;
    logic [7:0]  aa;
    logic [9:0]  ab;
    logic [15:0] da, qa;
    logic [3:0]  db, qb;
    int          failures = 0;
    int          tests_run = 0;
    initial forever #10 core_clk = ~core_clk;
    port_user #(.AW(8), .W(16)) user_a (.core_clk(core_clk), .go(go_a), .ctl(ctl), .addr(addr[7:0]),
        .din(din), .pclk(ca), .en(ea), .we(wa), .rst(ra), .pa(aa), .pd(da));
    port_user #(.AW(10), .W(4)) user_b (.core_clk(core_clk), .go(go_b), .ctl(ctl), .addr(addr),
        .din(din[3:0]), .pclk(cb), .en(eb), .we(wb), .rst(rb), .pa(ab), .pd(db));
    dual_port_block_ram #(.WIDTH_B(4)) DUT (.core_clk(core_clk), .rst_n(rst_n),
        .port_clk_a(ca), .port_en_a(ea), .port_we_a(wa), .port_rst_a(ra), .port_addr_a(aa),
        .write_data_in_a(da), .data_out_a(qa), .port_clk_b(cb), .port_en_b(eb), .port_we_b(wb),
        .port_rst_b(rb), .port_addr_b(ab), .write_data_in_b(db), .data_out_b(qb));
    task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    // ctl is {enable, write, reset}; p selects port b
    task automatic t(input bit p, input logic [2:0] c, input logic [9:0] a, input logic [15:0] d,
                     input logic [15:0] e);
        @(posedge core_clk);
        if (p) go_b <= 1'b1;
        else go_a <= 1'b1;
        ctl <= c;
        addr <= a;
        din <= d;
        @(posedge core_clk);
        go_a <= 1'b0;
        go_b <= 1'b0;
        @(posedge core_clk);
        #1;
        check(p ? "data_out_b" : "data_out_a", p ? {12'h000, qb} : qa, e);
    endtask
    task automatic after_reset();
        check("data_out_a", qa, 16'h0000);
        check("data_out_b", {12'h000, qb}, 16'h0000);
        t(0, 3'h4, 10'h005, 16'h0000, 16'h0000);
    endtask
    task automatic mixed_width();
        t(0, 3'h6, 10'h003, 16'hA5C3, 16'hA5C3);
        t(1, 3'h4, 10'h00C, 16'h0000, 16'h0003);
        t(1, 3'h4, 10'h00F, 16'h0000, 16'h000A);
        t(1, 3'h6, 10'h00D, 16'h0009, 16'h0009);
        t(0, 3'h4, 10'h003, 16'h0000, 16'hA593);
    endtask
    task automatic gated();
        t(0, 3'h2, 10'h003, 16'hFFFF, 16'hA593);
        t(0, 3'h4, 10'h003, 16'h0000, 16'hA593);
        repeat (3) @(posedge core_clk);
        #1;
        check("data_out_a", qa, 16'hA593);
    endtask
    task automatic out_reset();
        t(0, 3'h7, 10'h004, 16'h1234, 16'h0000);
        t(1, 3'h7, 10'h00E, 16'h0006, 16'h0000);
        t(0, 3'h4, 10'h003, 16'h0000, 16'hA693);
        t(0, 3'h4, 10'h004, 16'h0000, 16'h1234);
    endtask
    task automatic reload();
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        #1;
        check("data_out_a", qa, 16'h0000);
        check("data_out_b", {12'h000, qb}, 16'h0000);
        t(0, 3'h4, 10'h003, 16'h0000, 16'h0000);
        t(1, 3'h4, 10'h00D, 16'h0000, 16'h0000);
    endtask
    task automatic end_of_test();
        if (failures == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        after_reset();
        mixed_width();
        gated();
        out_reset();
        reload();
        end_of_test();
    end
    initial begin
        repeat (2000) @(posedge core_clk);
        failures++;
        end_of_test();
    end
endmodule // dual_port_block_ram_bench
bind dual_port_block_ram dual_port_block_ram_assertions #(.WIDTH_A(WIDTH_A), .WIDTH_B(WIDTH_B)) chk (
    .core_clk(core_clk), .rst_n(rst_n), .port_clk_a(port_clk_a), .port_en_a(port_en_a),
    .port_we_a(port_we_a), .port_rst_a(port_rst_a), .write_data_in_a(write_data_in_a),
    .data_out_a(data_out_a), .port_clk_b(port_clk_b), .port_en_b(port_en_b), .port_we_b(port_we_b),
    .port_rst_b(port_rst_b), .write_data_in_b(write_data_in_b), .data_out_b(data_out_b));
`default_nettype wire
